/* File: inc/fan_regs_pkg.sv */
// Register map, field positions, reset values and bus carriers for the fan duty register bank.
package fan_regs_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    // ==========================================================
    localparam logic [2:0][7:0] IDX_DUTY = {8'h32, 8'h31, 8'h30};
    localparam logic [2:0][7:0] IDX_TARGET = {8'h35, 8'h34, 8'h33};
    localparam logic [7:0] IDX_FLOOR_CTRL1 = 8'h36;
    localparam logic [2:0][7:0] IDX_TEMP = {8'h27, 8'h26, 8'h25};
    localparam logic [3:0][7:0] IDX_FAN_SPEED_INPUT_LO = {8'h2e, 8'h2c, 8'h2a, 8'h28};
    localparam logic [3:0][7:0] IDX_FAN_SPEED_INPUT_HI = {8'h2f, 8'h2d, 8'h2b, 8'h29};
    localparam logic [7:0] IDX_EXT_RES2 = 8'h77;
    localparam logic [7:0] IDX_CONFIG5 = 8'h7c;
    localparam logic [7:0] IDX_LOCK_CTRL = 8'h50;
    localparam logic [7:0] IDX_FAN_MODE = 8'h51;
    localparam logic [7:0] IDX_CORE_STATUS = 8'h52;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int CTRL1_CYCLE_MSB_BIT = 0;
    localparam int CTRL1_GUARD_BIT = 1;
    localparam int CTRL1_CAPTURE_LSB = 2;
    localparam int CTRL1_DYN_LSB = 5;
    localparam int EXT2_LSB = 2;
    localparam int CONFIG5_TWOS_BIT = 0;
    localparam int LOCK_BIT = 0;
    localparam int MODE_ALERT_BIT = 3;
    localparam int STATUS_CORE_LOW_BIT = 1;
    localparam int ADDR_IDX_LSB = 2;
    localparam int ADDR_IDX_MSB = 9;

    // ==========================================================
    // Reset values and codes
    // ==========================================================
    localparam logic [7:0] DUTY_RESET = 8'h00;
    localparam logic [7:0] TARGET_RESET = 8'ha4;
    localparam logic [7:0] FLOOR_CTRL1_RESET = 8'h00;
    localparam logic [7:0] DUTY_FULL = 8'hff;
    localparam logic [7:0] DUTY_STARTUP_READ = 8'h00;
    localparam logic [7:0] TEMP_OFFSET64 = 8'h40;
    localparam logic [7:0] FAULT_TWOS = 8'h80;
    localparam logic [7:0] FAULT_OFFSET64 = 8'h00;
    localparam logic [15:0] FAN_SPEED_INPUT_FAULT = 16'hffff;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // AXI4-Lite carriers
    // ==========================================================
    typedef struct packed {
        logic [31:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic arvalid;
        logic rready;
    } axil_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axil_rsp_s;

endpackage

/* File: core/pin_sync.sv */
// Three-stage input synchroniser that passes a bit once the second and third stages agree.
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Asynchronous inputs and their synchronised levels
    input wire logic [WIDTH-1:0] din_i,
    output logic [WIDTH-1:0] dout_o
);

    typedef struct packed {
        logic [WIDTH-1:0] ff1;
        logic [WIDTH-1:0] ff2;
        logic [WIDTH-1:0] ff3;
        logic [WIDTH-1:0] dout;
    } sync_s;

    sync_s s_reg;
    sync_s s_next;

    always_comb begin
        s_next = s_reg;
        s_next.ff1 = din_i;
        s_next.ff2 = s_reg.ff1;
        s_next.ff3 = s_reg.ff2;
        for (int i = 0; i < WIDTH; i++) begin
            if (s_reg.ff2[i] == s_reg.ff3[i]) begin
                s_next.dout[i] = s_reg.ff3[i];
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign dout_o = s_reg.dout;

endmodule

/* File: core/fan_duty_operating_point_regs.sv */
// Fan drive duty, operating point targets and adaptive floor control register bank on AXI4-Lite.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
module fan_duty_operating_point_regs (
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Register bus
    input wire fan_regs_pkg::axil_req_s axil_req_i,
    output fan_regs_pkg::axil_rsp_s axil_rsp_o,
    // Pins
    input wire logic thermal_alarm_pin_n_i,
    input wire logic standby_power_i,
    // Measurement and control loop inputs
    input wire logic core_voltage_low_i,
    input wire logic [2:0][7:0] temp_i,
    input wire logic [2:0][1:0] temp_ext_i,
    input wire logic [2:0] diode_fault_i,
    input wire logic [3:0][15:0] fan_speed_input_count_i,
    input wire logic [3:0] fan_speed_input_fault_i,
    input wire logic [2:0][7:0] auto_duty_i,
    input wire logic [2:0] fan_startup_i,
    // Fan drive and control loop outputs
    output logic [2:0][7:0] fan_duty_o,
    output logic [2:0] fan_pwm_o,
    output logic [2:0][7:0] target_temp_o,
    output logic [2:0] floor_adjust_en_o,
    output logic remote2_cycle_msb_o,
    output logic processor_hot_monitor_en_o,
    output logic shutdown_block_o,
    output logic alert_o
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [31:0] aw_addr;
        logic [7:0] w_byte;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [2:0][7:0] duty;
        logic [2:0][7:0] target;
        logic [7:0] ctrl1;
        logic lock;
        logic twos_fmt;
        logic [2:0] fan_auto;
        logic alert_en;
        logic core_low_flag;
        logic [2:0][7:0] temp_snap;
        logic [7:0] ext_snap;
        logic [2:0] frozen;
        logic [7:0] pwm_cnt;
        logic [2:0] pwm;
        logic [2:0] floor_en;
        logic hot_mon_en;
        logic shdn_block;
        logic alert;
        logic cycle_msb;
    } state_s;

    state_s s_reg;
    state_s s_next;

    logic [1:0] pins_sync;
    logic alarm;
    logic standby;
    logic guard;
    logic [2:0][7:0] rep_temp;
    logic [7:0] ext_live;
    logic [8:0] wdec;
    logic [8:0] rdec;
    logic [7:0] rd8;
    logic [15:0] fan_speed_input;

    // ==========================================================
    // Decoding helpers
    // ==========================================================
    // Returns the register index with a valid flag on top.
    function automatic logic [8:0] decode(input logic [31:0] addr);
        logic ok;
        ok = (addr[31:fan_regs_pkg::ADDR_IDX_MSB+1] == '0)
             && (addr[fan_regs_pkg::ADDR_IDX_LSB-1:0] == '0);
        return {ok, addr[fan_regs_pkg::ADDR_IDX_MSB:fan_regs_pkg::ADDR_IDX_LSB]};
    endfunction

    // Temperature in the selected format, with the fault code on a bad diode.
    function automatic logic [7:0] report_temp(input logic [7:0] raw, input logic fault,
                                               input logic twos);
        logic [7:0] v;
        if (fault) begin
            v = twos ? fan_regs_pkg::FAULT_TWOS : fan_regs_pkg::FAULT_OFFSET64;
        end else begin
            v = twos ? raw : 8'(raw + fan_regs_pkg::TEMP_OFFSET64);
        end
        return v;
    endfunction

    // ==========================================================
    // Pin synchronisation
    // ==========================================================
    // The alarm pin is inverted ahead of the chain so reset means no alarm.
    pin_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .din_i({standby_power_i, ~thermal_alarm_pin_n_i}),
        .dout_o(pins_sync)
    );

    assign alarm = pins_sync[0];
    assign standby = pins_sync[1];

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        s_next = s_reg;
        rd8 = 8'h00;
        fan_speed_input = 16'h0000;
        ext_live = 8'h00;
        wdec = decode(s_reg.aw_addr);
        rdec = decode(axil_req_i.araddr);
        guard = s_reg.ctrl1[fan_regs_pkg::CTRL1_GUARD_BIT] & standby & core_voltage_low_i;
        for (int ch = 0; ch < 3; ch++) begin
            rep_temp[ch] = report_temp(temp_i[ch], diode_fault_i[ch], s_reg.twos_fmt);
            ext_live[fan_regs_pkg::EXT2_LSB + 2*ch +: 2] = temp_ext_i[ch];
        end

        // Live readings refresh only while not frozen by an extended read.
        for (int ch = 0; ch < 3; ch++) begin
            if (!s_reg.frozen[ch]) begin
                s_next.temp_snap[ch] = rep_temp[ch];
            end
            if (s_reg.fan_auto[ch]) begin
                s_next.duty[ch] = auto_duty_i[ch];
            end
        end
        if (s_reg.frozen == 3'h0) begin
            s_next.ext_snap = ext_live;
        end

        // Write response retires before a new write can execute.
        if (s_reg.bvalid && axil_req_i.bready) begin
            s_next.bvalid = 1'b0;
        end

        if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid) begin
            s_next.aw_held = 1'b0;
            s_next.w_held = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = wdec[8] ? fan_regs_pkg::RESP_OKAY : fan_regs_pkg::RESP_SLVERR;
            if (wdec[8]) begin
                for (int ch = 0; ch < 3; ch++) begin
                    if (wdec[7:0] == fan_regs_pkg::IDX_DUTY[ch]) begin
                        if (s_reg.w_lane0 && !s_reg.fan_auto[ch]) begin
                            s_next.duty[ch] = s_reg.w_byte;
                        end
                    end
                    if (wdec[7:0] == fan_regs_pkg::IDX_TARGET[ch]) begin
                        if (s_reg.lock) begin
                            s_next.bresp = fan_regs_pkg::RESP_SLVERR;
                        end else if (s_reg.w_lane0) begin
                            s_next.target[ch] = s_reg.w_byte;
                        end
                    end
                end
                if (wdec[7:0] == fan_regs_pkg::IDX_FLOOR_CTRL1) begin
                    if (s_reg.lock) begin
                        s_next.bresp = fan_regs_pkg::RESP_SLVERR;
                    end else if (s_reg.w_lane0) begin
                        s_next.ctrl1 = s_reg.w_byte;
                    end
                end
                if (s_reg.w_lane0) begin
                    if (wdec[7:0] == fan_regs_pkg::IDX_CONFIG5) begin
                        s_next.twos_fmt = s_reg.w_byte[fan_regs_pkg::CONFIG5_TWOS_BIT];
                    end
                    if (wdec[7:0] == fan_regs_pkg::IDX_LOCK_CTRL
                        && s_reg.w_byte[fan_regs_pkg::LOCK_BIT]) begin
                        s_next.lock = 1'b1;
                    end
                    if (wdec[7:0] == fan_regs_pkg::IDX_FAN_MODE) begin
                        s_next.fan_auto = s_reg.w_byte[2:0];
                        s_next.alert_en = s_reg.w_byte[fan_regs_pkg::MODE_ALERT_BIT];
                    end
                    if (wdec[7:0] == fan_regs_pkg::IDX_CORE_STATUS
                        && s_reg.w_byte[fan_regs_pkg::STATUS_CORE_LOW_BIT]) begin
                        s_next.core_low_flag = 1'b0;
                    end
                end
            end
        end

        if (s_reg.awready && axil_req_i.awvalid) begin
            s_next.aw_held = 1'b1;
            s_next.aw_addr = axil_req_i.awaddr;
        end
        if (s_reg.wready && axil_req_i.wvalid) begin
            s_next.w_held = 1'b1;
            s_next.w_byte = axil_req_i.wdata[7:0];
            s_next.w_lane0 = axil_req_i.wstrb[0];
        end

        // Read channel: one word in flight, answered the cycle after acceptance.
        if (s_reg.rvalid && axil_req_i.rready) begin
            s_next.rvalid = 1'b0;
        end
        if (s_reg.arready && axil_req_i.arvalid) begin
            s_next.rvalid = 1'b1;
            s_next.rresp = fan_regs_pkg::RESP_SLVERR;
            if (rdec[8]) begin
                for (int ch = 0; ch < 3; ch++) begin
                    if (rdec[7:0] == fan_regs_pkg::IDX_DUTY[ch]) begin
                        s_next.rresp = fan_regs_pkg::RESP_OKAY;
                        rd8 = fan_startup_i[ch] ? fan_regs_pkg::DUTY_STARTUP_READ
                                                : s_reg.duty[ch];
                    end
                    if (rdec[7:0] == fan_regs_pkg::IDX_TARGET[ch]) begin
                        s_next.rresp = fan_regs_pkg::RESP_OKAY;
                        rd8 = s_reg.target[ch];
                    end
                    if (rdec[7:0] == fan_regs_pkg::IDX_TEMP[ch]) begin
                        s_next.rresp = fan_regs_pkg::RESP_OKAY;
                        rd8 = s_reg.frozen[ch] ? s_reg.temp_snap[ch] : rep_temp[ch];
                        s_next.frozen[ch] = 1'b0;
                    end
                end
                for (int f = 0; f < 4; f++) begin
                    fan_speed_input = fan_speed_input_fault_i[f] ? fan_regs_pkg::FAN_SPEED_INPUT_FAULT
                                                      : fan_speed_input_count_i[f];
                    if (rdec[7:0] == fan_regs_pkg::IDX_FAN_SPEED_INPUT_LO[f]) begin
                        s_next.rresp = fan_regs_pkg::RESP_OKAY;
                        rd8 = fan_speed_input[7:0];
                    end
                    if (rdec[7:0] == fan_regs_pkg::IDX_FAN_SPEED_INPUT_HI[f]) begin
                        s_next.rresp = fan_regs_pkg::RESP_OKAY;
                        rd8 = fan_speed_input[15:8];
                    end
                end
                if (rdec[7:0] == fan_regs_pkg::IDX_EXT_RES2) begin
                    s_next.rresp = fan_regs_pkg::RESP_OKAY;
                    if (s_reg.frozen == 3'h0) begin
                        rd8 = ext_live;
                        s_next.ext_snap = ext_live;
                        for (int ch = 0; ch < 3; ch++) begin
                            s_next.temp_snap[ch] = rep_temp[ch];
                        end
                    end else begin
                        rd8 = s_reg.ext_snap;
                    end
                    s_next.frozen = 3'h7;
                end
                if (rdec[7:0] == fan_regs_pkg::IDX_FLOOR_CTRL1) begin
                    s_next.rresp = fan_regs_pkg::RESP_OKAY;
                    rd8 = s_reg.ctrl1;
                end
                if (rdec[7:0] == fan_regs_pkg::IDX_CONFIG5) begin
                    s_next.rresp = fan_regs_pkg::RESP_OKAY;
                    rd8[fan_regs_pkg::CONFIG5_TWOS_BIT] = s_reg.twos_fmt;
                end
                if (rdec[7:0] == fan_regs_pkg::IDX_LOCK_CTRL) begin
                    s_next.rresp = fan_regs_pkg::RESP_OKAY;
                    rd8[fan_regs_pkg::LOCK_BIT] = s_reg.lock;
                end
                if (rdec[7:0] == fan_regs_pkg::IDX_FAN_MODE) begin
                    s_next.rresp = fan_regs_pkg::RESP_OKAY;
                    rd8[2:0] = s_reg.fan_auto;
                    rd8[fan_regs_pkg::MODE_ALERT_BIT] = s_reg.alert_en;
                end
                if (rdec[7:0] == fan_regs_pkg::IDX_CORE_STATUS) begin
                    s_next.rresp = fan_regs_pkg::RESP_OKAY;
                    rd8[fan_regs_pkg::STATUS_CORE_LOW_BIT] = s_reg.core_low_flag;
                end
            end
            s_next.rdata = {24'h000000, rd8};
        end

        // Alarm capture overrides a host write to the same target in the same cycle.
        for (int ch = 0; ch < 3; ch++) begin
            if (alarm && s_reg.ctrl1[fan_regs_pkg::CTRL1_CAPTURE_LSB + ch]) begin
                s_next.target[ch] = rep_temp[ch];
            end
        end

        // Guard sets the sticky flag after the clear so a simultaneous event wins.
        if (guard) begin
            s_next.core_low_flag = 1'b1;
        end
        s_next.floor_en = s_reg.ctrl1[fan_regs_pkg::CTRL1_DYN_LSB +: 3] & {3{~guard}};
        s_next.hot_mon_en = ~guard;
        s_next.shdn_block = guard;
        s_next.alert = s_next.core_low_flag & s_reg.alert_en;
        s_next.cycle_msb = s_reg.ctrl1[fan_regs_pkg::CTRL1_CYCLE_MSB_BIT];

        // Linear duty: the compare against a free-running count spans 0 to 100 percent.
        s_next.pwm_cnt = 8'(s_reg.pwm_cnt + 8'h01);
        for (int ch = 0; ch < 3; ch++) begin
            s_next.pwm[ch] = (s_reg.duty[ch] == fan_regs_pkg::DUTY_FULL)
                             || (s_reg.pwm_cnt < s_reg.duty[ch]);
        end

        s_next.awready = !s_next.aw_held && !s_next.bvalid;
        s_next.wready = !s_next.w_held && !s_next.bvalid;
        s_next.arready = !s_next.rvalid;
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            s_reg <= '0;
            s_reg.awready <= 1'b1;
            s_reg.wready <= 1'b1;
            s_reg.arready <= 1'b1;
            s_reg.hot_mon_en <= 1'b1;
            s_reg.duty <= {3{fan_regs_pkg::DUTY_RESET}};
            s_reg.target <= {3{fan_regs_pkg::TARGET_RESET}};
            s_reg.ctrl1 <= fan_regs_pkg::FLOOR_CTRL1_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign axil_rsp_o.awready = s_reg.awready;
    assign axil_rsp_o.wready = s_reg.wready;
    assign axil_rsp_o.bresp = s_reg.bresp;
    assign axil_rsp_o.bvalid = s_reg.bvalid;
    assign axil_rsp_o.arready = s_reg.arready;
    assign axil_rsp_o.rdata = s_reg.rdata;
    assign axil_rsp_o.rresp = s_reg.rresp;
    assign axil_rsp_o.rvalid = s_reg.rvalid;
    assign fan_duty_o = s_reg.duty;
    assign fan_pwm_o = s_reg.pwm;
    assign target_temp_o = s_reg.target;
    assign floor_adjust_en_o = s_reg.floor_en;
    assign remote2_cycle_msb_o = s_reg.cycle_msb;
    assign processor_hot_monitor_en_o = s_reg.hot_mon_en;
    assign shutdown_block_o = s_reg.shdn_block;
    assign alert_o = s_reg.alert;

endmodule

/* File: tb/fan_regs_sva.sv */
// Assertion checker for the fan duty and operating point register bank.
`timescale 1ns/1ps
module fan_regs_sva (
    // Clock, reset and register bus
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire fan_regs_pkg::axil_req_s axil_req_i,
    input wire fan_regs_pkg::axil_rsp_s axil_rsp_o,
    // Fan drive, guard and targets
    input wire logic core_voltage_low_i,
    input wire logic [2:0][7:0] fan_duty_o,
    input wire logic [2:0] fan_pwm_o,
    input wire logic [2:0][7:0] target_temp_o,
    input wire logic [2:0] floor_adjust_en_o,
    input wire logic remote2_cycle_msb_o,
    input wire logic processor_hot_monitor_en_o,
    input wire logic shutdown_block_o
);
    // ==========================================================
    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    chk_target_reset: assert property ($rose(nrst_i) |-> target_temp_o == {3{8'ha4}})
        else $error("operating points not at reset code");
    chk_ctrl_reset: assert property ($rose(nrst_i) |-> floor_adjust_en_o == 3'h0
        && !remote2_cycle_msb_o && fan_duty_o == 24'h0) else $error("control not cleared");
    chk_pwm_full: assert property ((fan_duty_o[0] == 8'hff)[*2] |-> fan_pwm_o[0])
        else $error("full duty output not high");
    chk_pwm_zero: assert property ((fan_duty_o[1] == 8'h00)[*2] |-> !fan_pwm_o[1])
        else $error("zero duty output not low");
    chk_guard_effects: assert property (shutdown_block_o |-> !processor_hot_monitor_en_o
        && floor_adjust_en_o == 3'h0) else $error("guard left functions running");
    chk_guard_release: assert property (!core_voltage_low_i[*2] |-> !shutdown_block_o)
        else $error("guard held after core recovered");
    chk_read_answer: assert property (axil_req_i.arvalid && axil_rsp_o.arready
        |=> axil_rsp_o.rvalid) else $error("read answer late");
    chk_resp_hold: assert property (axil_rsp_o.bvalid && !axil_req_i.bready
        |=> axil_rsp_o.bvalid && $stable(axil_rsp_o.bresp)) else $error("write answer dropped");
    chk_rdata_hold: assert property (axil_rsp_o.rvalid && !axil_req_i.rready
        |=> axil_rsp_o.rvalid && $stable(axil_rsp_o.rdata)) else $error("read answer dropped");
    cover property (shutdown_block_o);
    cover property (axil_rsp_o.bvalid && axil_rsp_o.bresp == 2'h2);
    cover property ($rose(fan_pwm_o[2]));
endmodule

bind fan_duty_operating_point_regs fan_regs_sva u_sva (.clock_i(clock_i), .nrst_i(nrst_i),
    .axil_req_i(axil_req_i), .axil_rsp_o(axil_rsp_o), .core_voltage_low_i(core_voltage_low_i),
    .fan_duty_o(fan_duty_o), .fan_pwm_o(fan_pwm_o), .target_temp_o(target_temp_o),
    .floor_adjust_en_o(floor_adjust_en_o), .remote2_cycle_msb_o(remote2_cycle_msb_o),
    .processor_hot_monitor_en_o(processor_hot_monitor_en_o),
    .shutdown_block_o(shutdown_block_o));

/* File: tb/fan_host_model.sv */
// Register bus host model issuing single AXI4-Lite reads and writes.
`timescale 1ns/1ps
module fan_host_model (
    // Clock
    input wire logic clock_i,
    // Register bus
    output fan_regs_pkg::axil_req_s req_o,
    input wire fan_regs_pkg::axil_rsp_s rsp_i
);
    initial req_o = '0;
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] resp);
        @(posedge clock_i);
        req_o.awaddr <= {22'h0, idx, 2'h0};
        req_o.wdata <= {24'h0, d};
        req_o.wstrb <= 4'hf;
        req_o.awvalid <= 1'b1;
        req_o.wvalid <= 1'b1;
        do begin
            @(posedge clock_i);
            if (req_o.awvalid && rsp_i.awready) req_o.awvalid <= 1'b0;
            if (req_o.wvalid && rsp_i.wready) req_o.wvalid <= 1'b0;
            if (rsp_i.bvalid && !req_o.bready) req_o.bready <= 1'b1;
        end while (!(rsp_i.bvalid && req_o.bready));
        resp = rsp_i.bresp;
        req_o.bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] idx, output logic [7:0] d, output logic [1:0] resp);
        @(posedge clock_i);
        req_o.araddr <= {22'h0, idx, 2'h0};
        req_o.arvalid <= 1'b1;
        do begin
            @(posedge clock_i);
            if (req_o.arvalid && rsp_i.arready) req_o.arvalid <= 1'b0;
            if (rsp_i.rvalid && !req_o.rready) req_o.rready <= 1'b1;
        end while (!(rsp_i.rvalid && req_o.rready));
        d = rsp_i.rdata[7:0];
        resp = rsp_i.rresp;
        req_o.rready <= 1'b0;
    endtask
endmodule

/* File: tb/fan_duty_operating_point_regs_tb.sv */
// Self-checking testbench for the fan duty and operating point register bank.
`timescale 1ns/1ps
module fan_duty_operating_point_regs_tb;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    fan_regs_pkg::axil_req_s req;
    fan_regs_pkg::axil_rsp_s rsp;
    logic alarm_n = 1'b1, standby = 1'b0, core_low = 1'b0, msb, hot_en, sd_block, alert;
    logic [2:0][7:0] temp = 24'h0, auto_duty = 24'h0, duty, target;
    logic [2:0] dfault = 3'h0, startup = 3'h0, pwm, floor_en;
    logic [3:0][15:0] fan_speed_input = 64'h5555_0000_0000_1234;
    logic [3:0] tfault = 4'h0;
    logic [2:0][1:0] ext = 6'h39;
    logic [7:0] rd_v;
    logic [1:0] resp;
    int error_cnt = 0, checks_done = 0, cycles = 0, hi;
    fan_host_model host (.clock_i(clock_i), .req_o(req), .rsp_i(rsp));
    fan_duty_operating_point_regs DUT (.clock_i(clock_i), .nrst_i(nrst_i), .axil_req_i(req),
        .axil_rsp_o(rsp), .thermal_alarm_pin_n_i(alarm_n), .standby_power_i(standby),
        .core_voltage_low_i(core_low), .temp_i(temp), .temp_ext_i(ext),
        .diode_fault_i(dfault), .fan_speed_input_count_i(fan_speed_input), .fan_speed_input_fault_i(tfault),
        .auto_duty_i(auto_duty), .fan_startup_i(startup), .fan_duty_o(duty), .fan_pwm_o(pwm),
        .target_temp_o(target), .floor_adjust_en_o(floor_en), .remote2_cycle_msb_o(msb),
        .processor_hot_monitor_en_o(hot_en), .shutdown_block_o(sd_block), .alert_o(alert));
    always #10 clock_i = ~clock_i;
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] exp);
        host.wr(idx, d, resp);
        chk(8'(resp), 8'(exp));
    endtask
    task rd(input logic [7:0] idx, input logic [7:0] exp);
        host.rd(idx, rd_v, resp);
        chk(rd_v, exp);
    endtask
    task complete_run;
        if (error_cnt == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            error_cnt++;
            complete_run();
        end
    end
    initial begin
        repeat (4) @(posedge clock_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 7; i++) rd(8'h30 + 8'(i), (i > 2 && i < 6) ? 8'ha4 : 8'h00);
        wr(8'h30, 8'hff, 2'h0);
        chk(duty[0], 8'hff);
        wr(8'h32, 8'h80, 2'h0);
        rd(8'h30, 8'hff);
        hi = 0;
        repeat (256) begin
            @(posedge clock_i);
            hi += int'(pwm[2]);
        end
        chk(8'(hi), 8'h80);
        startup <= 3'h4;
        rd(8'h32, 8'h00);
        startup <= 3'h0;
        auto_duty <= 24'h5a;
        wr(8'h51, 8'h07, 2'h0);
        wr(8'h30, 8'h11, 2'h0);
        rd(8'h30, 8'h5a);
        wr(8'h51, 8'h08, 2'h0);
        temp <= 24'h2d19;
        dfault <= 3'h4;
        rd(8'h25, 8'h59);
        rd(8'h27, 8'h00);
        wr(8'h7c, 8'h01, 2'h0);
        rd(8'h27, 8'h80);
        dfault <= 3'h0;
        rd(8'h77, 8'he4);
        temp <= 24'h2d22;
        ext <= 6'h00;
        rd(8'h77, 8'he4);
        rd(8'h25, 8'h19);
        rd(8'h25, 8'h22);
        rd(8'h26, 8'h2d);
        rd(8'h27, 8'h00);
        rd(8'h77, 8'h00);
        wr(8'h36, 8'h04, 2'h0);
        alarm_n <= 1'b0;
        repeat (8) @(posedge clock_i);
        chk(target[0], 8'h22);
        chk(target[1], 8'ha4);
        wr(8'h36, 8'he9, 2'h0);
        temp <= 24'h2d30;
        repeat (2) @(posedge clock_i);
        alarm_n <= 1'b1;
        chk(target[1], 8'h2d);
        chk(target[0], 8'h22);
        chk(8'(msb), 8'h01);
        chk(8'(floor_en), 8'h07);
        wr(8'h35, 8'h50, 2'h0);
        standby <= 1'b1;
        core_low <= 1'b1;
        wr(8'h36, 8'heb, 2'h0);
        repeat (6) @(posedge clock_i);
        chk(8'({sd_block, hot_en, alert, floor_en}), 8'h28);
        rd(8'h52, 8'h02);
        core_low <= 1'b0;
        repeat (3) @(posedge clock_i);
        chk(8'({sd_block, hot_en, alert, floor_en}), 8'h1f);
        wr(8'h52, 8'h02, 2'h0);
        chk(8'(alert), 8'h00);
        wr(8'h50, 8'h01, 2'h0);
        wr(8'h35, 8'h10, 2'h2);
        rd(8'h35, 8'h50);
        wr(8'h36, 8'h00, 2'h2);
        rd(8'h36, 8'heb);
        host.rd(8'h60, rd_v, resp);
        chk(8'(resp), 8'h02);
        tfault <= 4'h8;
        rd(8'h28, 8'h34);
        rd(8'h29, 8'h12);
        rd(8'h2e, 8'hff);
        rd(8'h2f, 8'hff);
        complete_run();
    end
endmodule
